// ---- logic/lfp_fan_pwm.sv ----
// Function
// - Output duty is the duty value over the full-scale value of the frequency code.
// - The period is 2N ticks of the selected internal clock, 360 kHz or 1.4 kHz.
// - High resolution uses eight duty bits, FF full, at 22.5 kHz, never on the slow clock.
// - A twelve-entry table pairs temperature setpoints with duty values.
// - Without smoothing the duty jumps to the new entry's value at once.
// - Below the first setpoint the duty is zero.
// - Between two setpoints the lower entry's duty holds.
// - With smoothing the duty steps one LSB per interval toward the new value.
// - A setpoint is passed only when temperature exceeds it by 1 or 0.5 degree.
// - On falling temperature setpoints are lowered by the hysteresis amount.
// - An active critical temperature output forces full duty at once.
// - The step interval is 0.182, 0.091, 0.046 or 0.023 s for every smoothing step, up or down.
`timescale 1ns/10ps
`default_nettype none
`include "lfp_params.svh"
module lfp_fan_pwm
    import lfp_pkg::*;
#(
    parameter int unsigned SLOW_DIV = `LFP_DIV(`LFP_SLOW_HZ),
    parameter int unsigned STEP_CYC_0 = `LFP_US_CYC(`LFP_STEP0_US),
    parameter int unsigned STEP_CYC_1 = `LFP_US_CYC(`LFP_STEP1_US),
    parameter int unsigned STEP_CYC_2 = `LFP_US_CYC(`LFP_STEP2_US),
    parameter int unsigned STEP_CYC_3 = `LFP_US_CYC(`LFP_STEP3_US)
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [8:0] remote_temp,
    input wire logic critical_temp_output,
    input wire logic fan_pin_i,
    output logic fan_pin_o,
    output logic fan_pin_oe_n
);
    localparam logic [14:0] FAST_DIV = 15'(`LFP_DIV(`LFP_FAST_HZ));
    localparam logic [14:0] HR_DIV = 15'(`LFP_DIV(`LFP_HR_HZ));

    // count of entries whose setpoint (less offset) the temperature has passed
    function automatic logic [3:0] lfp_count(input logic [8:0] t, input logic [9:0] off,
                                             input lfp_tbl_t sp, input logic half);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 12; i++) begin
            if ({1'b0, t} + off >= {1'b0, sp[i], 1'b0} + (half ? 10'h001 : 10'h002)) begin
                n = 4'(i + 1);
            end
        end
        return n;
    endfunction : lfp_count

    // register file
    logic [7:0] enh_q, enh_d, pcfg_q, pcfg_d, duty_q, duty_d, freq_q, freq_d;
    logic [7:0] hyst_q, hyst_d, smooth_q, smooth_d, rdata_d;
    lfp_tbl_t lut_temp_q, lut_temp_d, lut_duty_q, lut_duty_d;
    logic [7:0] lut_off;
    logic [7:0] cur_q, cur_d;
    lfp_ramp_t ramp_q, ramp_d;
    logic pin_s1_q, pin_s2_q;

    always_comb begin
        enh_d = enh_q;
        pcfg_d = pcfg_q;
        duty_d = duty_q;
        freq_d = freq_q;
        hyst_d = hyst_q;
        smooth_d = smooth_q;
        lut_temp_d = lut_temp_q;
        lut_duty_d = lut_duty_q;
        lut_off = reg_addr - `LFP_ADDR_LUT;
        if (reg_we) begin
            case (reg_addr)
                `LFP_ADDR_ENH: enh_d = reg_wdata;
                `LFP_ADDR_PCFG: pcfg_d = reg_wdata;
                `LFP_ADDR_DUTY: duty_d = reg_wdata;
                `LFP_ADDR_FREQ: freq_d = reg_wdata;
                `LFP_ADDR_HYST: hyst_d = reg_wdata;
                `LFP_ADDR_SMOOTH: smooth_d = reg_wdata;
                default: begin
                    if (reg_addr >= `LFP_ADDR_LUT && reg_addr <= `LFP_ADDR_LUT_END) begin
                        if (lut_off[0]) begin
                            lut_duty_d[lut_off[4:1]] = reg_wdata;
                        end else begin
                            lut_temp_d[lut_off[4:1]] = reg_wdata;
                        end
                    end
                end
            endcase
        end
        case (reg_addr)
            `LFP_ADDR_ENH: rdata_d = enh_q;
            `LFP_ADDR_PCFG: rdata_d = pcfg_q;
            `LFP_ADDR_DUTY: rdata_d = duty_q;
            `LFP_ADDR_FREQ: rdata_d = freq_q;
            `LFP_ADDR_HYST: rdata_d = hyst_q;
            `LFP_ADDR_SMOOTH: rdata_d = smooth_q;
            `LFP_ADDR_CUR: rdata_d = cur_q;
            `LFP_ADDR_STAT: rdata_d = {5'h00, pin_s2_q, ramp_q};
            default: begin
                rdata_d = 8'h00;
                if (reg_addr >= `LFP_ADDR_LUT && reg_addr <= `LFP_ADDR_LUT_END) begin
                    rdata_d = lut_off[0] ? lut_duty_q[lut_off[4:1]] : lut_temp_q[lut_off[4:1]];
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enh_q <= `LFP_RST_ENH;
            pcfg_q <= `LFP_RST_PCFG;
            duty_q <= `LFP_RST_DUTY;
            freq_q <= `LFP_RST_FREQ;
            hyst_q <= `LFP_RST_HYST;
            smooth_q <= `LFP_RST_SMOOTH;
            lut_temp_q <= {12{`LFP_RST_LUT_TEMP}};
            lut_duty_q <= {12{`LFP_RST_LUT_DUTY}};
            reg_rdata <= 8'h00;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else if (clk_en) begin
            enh_q <= enh_d;
            pcfg_q <= pcfg_d;
            duty_q <= duty_d;
            freq_q <= freq_d;
            hyst_q <= hyst_d;
            smooth_q <= smooth_d;
            lut_temp_q <= lut_temp_d;
            lut_duty_q <= lut_duty_d;
            reg_rdata <= rdata_d;
            pin_s1_q <= fan_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // period generation
    logic [14:0] div_q, div_d, div_top;
    logic [7:0] pcnt_q, pcnt_d, period, applied;
    logic [4:0] code;
    logic hr_active, tick, pwm_high_q, pwm_high_d, tbl_en;

    always_comb begin
        tbl_en = pcfg_q[`LFP_TBL_EN_BIT];
        code = (freq_q[4:0] == 5'h00) ? 5'h01 : freq_q[4:0];
        hr_active = enh_q[`LFP_HR_BIT] && !pcfg_q[`LFP_CKSEL_BIT]
                    && freq_q[4:0] == `LFP_HR_CODE;
        period = hr_active ? `LFP_HR_PERIOD : {2'b00, code, 1'b0};
        if (hr_active) begin
            div_top = HR_DIV;
        end else if (pcfg_q[`LFP_CKSEL_BIT]) begin
            div_top = 15'(SLOW_DIV);
        end else begin
            div_top = FAST_DIV;
        end
        tick = (div_q >= div_top - 15'h0001);
        div_d = tick ? 15'h0000 : div_q + 15'h0001;
        pcnt_d = pcnt_q;
        if (tick) begin
            pcnt_d = (pcnt_q >= period - 8'h01) ? 8'h00 : pcnt_q + 8'h01;
        end
        applied = tbl_en ? cur_q : duty_q;
        // critical bypasses smoothing so the fan is full on the next edge
        pwm_high_d = critical_temp_output || applied >= period
                     || pcnt_q < applied;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 15'h0000;
            pcnt_q <= 8'h00;
            pwm_high_q <= 1'b1;
        end else if (clk_en) begin
            div_q <= div_d;
            pcnt_q <= pcnt_d;
            pwm_high_q <= pwm_high_d;
        end
    end

    // open drain: only ever pulls low
    assign fan_pin_o = 1'b0;
    assign fan_pin_oe_n = pwm_high_q;

    // table index and smoothing
    logic [3:0] idx_q, idx_d, rise_n, fall_n;
    logic [22:0] step_q, step_d, step_top;
    logic [7:0] tgt;
    logic sm_en, step;

    always_comb begin
        rise_n = lfp_count(remote_temp, 10'h000, lut_temp_q,
                           smooth_q[`LFP_HALF_RES_BIT]);
        fall_n = lfp_count(remote_temp, {1'b0, hyst_q, 1'b0}, lut_temp_q,
                           smooth_q[`LFP_HALF_RES_BIT]);
        if (rise_n > idx_q) begin
            idx_d = rise_n;
        end else if (fall_n < idx_q) begin
            idx_d = fall_n;
        end else begin
            idx_d = idx_q;
        end
        tgt = (idx_q == 4'h0) ? 8'h00 : lut_duty_q[idx_q - 4'h1];
        sm_en = smooth_q[`LFP_SM_EN_BIT];
        case (smooth_q[1:0])
            2'b00: step_top = 23'(STEP_CYC_0 - 1);
            2'b01: step_top = 23'(STEP_CYC_1 - 1);
            2'b10: step_top = 23'(STEP_CYC_2 - 1);
            default: step_top = 23'(STEP_CYC_3 - 1);
        endcase
        step = sm_en && step_q >= step_top;
        step_d = (step || !sm_en) ? 23'h000000 : step_q + 23'h000001;
        cur_d = cur_q;
        if (!sm_en) begin
            cur_d = tgt;
        end else if (step) begin
            // direction from the live target: the ramp state lags a table move by one edge
            if (cur_q < tgt) begin
                cur_d = cur_q + 8'h01;
            end else if (cur_q > tgt) begin
                cur_d = cur_q - 8'h01;
            end
        end
        if (cur_d < tgt) begin
            ramp_d = LFP_RAMP_UP;
        end else if (cur_d > tgt) begin
            ramp_d = LFP_RAMP_DOWN;
        end else begin
            ramp_d = LFP_RAMP_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= 4'h0;
            step_q <= 23'h000000;
            cur_q <= 8'h00;
            ramp_q <= LFP_RAMP_IDLE;
        end else if (clk_en) begin
            idx_q <= idx_d;
            step_q <= step_d;
            cur_q <= cur_d;
            ramp_q <= ramp_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ramp_step;
        clk_en && sm_en && step && cur_q != tgt;
    endsequence

    a_crit_forces_full: assert property ((clk_en && critical_temp_output) |=> fan_pin_oe_n)
        else $error("critical input did not force full duty");
    a_period_wrap: assert property ((clk_en && tick && pcnt_q >= period - 8'h01) |=> pcnt_q == 8'h00)
        else $error("period counter did not wrap at 2N");
    a_code_zero: assert property ((freq_q[4:0] == 5'h00) |-> period == 8'h02)
        else $error("code zero not treated as one");
    a_hr_period: assert property ((hr_active && !pcfg_q[`LFP_CKSEL_BIT]) |-> period == 8'hFF)
        else $error("high resolution period wrong");
    a_duty_low: assert property ((clk_en && !critical_temp_output && applied < period
                                  && pcnt_q >= applied) |=> !fan_pin_oe_n)
        else $error("output high outside duty window");
    a_rise_index: assert property ((clk_en && rise_n > idx_q) |=> idx_q == $past(rise_n))
        else $error("rising index not taken");
    a_hyst_fall: assert property ((clk_en && rise_n <= idx_q && fall_n < idx_q)
                                  |=> idx_q == $past(fall_n))
        else $error("falling index ignores hysteresis");
    a_index_hold: assert property ((clk_en && rise_n <= idx_q && fall_n >= idx_q) |=> $stable(idx_q))
        else $error("index moved between setpoints");
    a_below_first: assert property ((idx_q == 4'h0) |-> tgt == 8'h00)
        else $error("nonzero duty below first setpoint");
    a_no_smooth_jump: assert property ((clk_en && !sm_en) |=> cur_q == $past(tgt))
        else $error("duty did not jump without smoothing");
    a_smooth_step: assert property (s_ramp_step |=> (cur_q == $past(cur_q) + 8'h01
                                    || cur_q == $past(cur_q) - 8'h01))
        else $error("smoothing step not one LSB");
    a_smooth_hold: assert property ((clk_en && sm_en && !step) |=> $stable(cur_q))
        else $error("duty moved between step intervals");
    // tick spacing and duty window, then the direction of each smoothing step
    a_tick_restart: assert property ((clk_en && tick) |=> div_q == 15'h0000)
        else $error("tick divider did not restart");
    a_count_hold: assert property ((clk_en && !tick) |=> $stable(pcnt_q))
        else $error("period counter moved without a tick");
    a_full_duty: assert property ((clk_en && applied >= period) |=> fan_pin_oe_n)
        else $error("full duty did not release the pin");
    a_duty_high: assert property ((clk_en && pcnt_q < applied) |=> fan_pin_oe_n)
        else $error("output low inside duty window");
    a_step_up: assert property ((clk_en && step && cur_q < tgt)
                               |=> cur_q == $past(cur_q) + 8'h01)
        else $error("smoothing did not step up");
    a_step_down: assert property ((clk_en && step && cur_q > tgt)
                                 |=> cur_q == $past(cur_q) - 8'h01)
        else $error("smoothing did not step down");
endmodule : lfp_fan_pwm
`default_nettype wire

// ---- logic/lfp_params.svh ----
`ifndef LFP_PARAMS_SVH
`define LFP_PARAMS_SVH
`define LFP_CLK_HZ 40000000
`define LFP_FAST_HZ 360000
`define LFP_SLOW_HZ 1400
// 22.5 kHz times 255 fine ticks per period
`define LFP_HR_HZ 5737500
`define LFP_DIV(hz) ((`LFP_CLK_HZ + (hz) / 2) / (hz))
`define LFP_STEP0_US 182000
`define LFP_STEP1_US 91000
`define LFP_STEP2_US 46000
`define LFP_STEP3_US 23000
`define LFP_US_CYC(us) ((`LFP_CLK_HZ / 1000000) * (us))
`define LFP_ADDR_ENH 8'h45
`define LFP_ADDR_PCFG 8'h4A
`define LFP_ADDR_DUTY 8'h4C
`define LFP_ADDR_FREQ 8'h4D
`define LFP_ADDR_HYST 8'h4E
`define LFP_ADDR_SMOOTH 8'h4F
`define LFP_ADDR_CUR 8'h48
`define LFP_ADDR_STAT 8'h4B
`define LFP_ADDR_LUT 8'h50
`define LFP_ADDR_LUT_END 8'h67
`define LFP_HR_BIT 4
`define LFP_CKSEL_BIT 3
`define LFP_TBL_EN_BIT 5
`define LFP_SM_EN_BIT 5
`define LFP_HALF_RES_BIT 2
`define LFP_HR_CODE 5'h08
`define LFP_HR_PERIOD 8'hFF
`define LFP_FULL_DUTY 8'hFF
`define LFP_RST_ENH 8'h00
`define LFP_RST_PCFG 8'h00
`define LFP_RST_DUTY 8'h00
`define LFP_RST_FREQ 8'h08
`define LFP_RST_HYST 8'h04
`define LFP_RST_SMOOTH 8'h00
`define LFP_RST_LUT_TEMP 8'hFF
`define LFP_RST_LUT_DUTY 8'h00
`endif

// ---- logic/lfp_pkg.sv ----
package lfp_pkg;
    typedef logic [11:0][7:0] lfp_tbl_t;
    typedef enum logic [1:0] {
        LFP_RAMP_IDLE = 2'b00,
        LFP_RAMP_UP = 2'b01,
        LFP_RAMP_DOWN = 2'b10
    } lfp_ramp_t;
endpackage : lfp_pkg

// ---- test/lfp_fan_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lfp_fan_model (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic fan_pin_o,
    input wire logic fan_pin_oe_n,
    output logic pin,
    output int hi_cnt
);
    // fan input has a pull-up: a released line reads high, never the last driven value
    assign pin = fan_pin_oe_n ? 1'b1 : fan_pin_o;
    // high time is what spins the fan, so count it per window
    always @(posedge core_clk) begin
        if (clr) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= hi_cnt + int'(pin === 1'b1);
        end
    end
endmodule : lfp_fan_model
`default_nettype wire

// ---- test/lut_fan_pwm_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module lut_fan_pwm_control_test;
    logic core_clk, reset_n, clk_en, reg_we, crit, clr, pin, fan_pin_o, fan_pin_oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [8:0] remote_temp;
    int hi_cnt, fail_count, tests_run;
    // shortened counts keep the run brief
    lfp_fan_pwm #(.SLOW_DIV(8), .STEP_CYC_0(20), .STEP_CYC_1(10), .STEP_CYC_2(6),
        .STEP_CYC_3(4)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .remote_temp(remote_temp), .critical_temp_output(crit), .fan_pin_i(pin),
        .fan_pin_o(fan_pin_o), .fan_pin_oe_n(fan_pin_oe_n));
    lfp_fan_model u_fan (.core_clk(core_clk), .clr(clr), .fan_pin_o(fan_pin_o),
        .fan_pin_oe_n(fan_pin_oe_n), .pin(pin), .hi_cnt(hi_cnt));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task automatic summarize;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // an extra edge after the strobe so back-to-back writes never retoggle it at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge core_clk);
        reg_we = 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        @(negedge core_clk);
        check(reg_rdata, e);
    endtask : rchk
    task automatic pwm(input int per, input int hi);
        repeat (2000) @(negedge core_clk);
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        repeat (per) @(negedge core_clk);
        check(hi_cnt, hi);
    endtask : pwm
    task automatic t_regs;
        logic [7:0] a[8] = '{8'h45, 8'h4A, 8'h4C, 8'h4D, 8'h4E, 8'h50, 8'h67, 8'h30};
        logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'hFF, 8'h00, 8'h00};
        for (int k = 0; k < 8; k++) begin
            rchk(a[k], e[k]);
        end
        clk_en = 1'b0;
        wr(8'h4C, 8'h55);
        clk_en = 1'b1;
        wr(8'h48, 8'h77);
        rchk(8'h4C, 8'h00);
        rchk(8'h48, 8'h00);
        $display("done regs");
    endtask : t_regs
    task automatic t_pwm;
        logic [7:0] pc[11] = '{0, 0, 0, 0, 0, 8'h08, 0, 0, 8'h08, 0, 0};
        logic [7:0] en[11] = '{0, 0, 0, 0, 0, 0, 8'h10, 8'h10, 8'h10, 8'h10, 0};
        logic [7:0] fq[11] = '{1, 0, 3, 3, 1, 2, 8, 8, 8, 9, 1};
        logic [7:0] du[11] = '{1, 1, 5, 6, 0, 3, 8'h80, 8'hFF, 8'h80, 5, 0};
        int per[11] = '{222, 222, 666, 666, 222, 32, 1785, 1785, 128, 1998, 222};
        int hi[11] = '{111, 111, 555, 666, 0, 24, 896, 1785, 128, 555, 222};
        for (int k = 0; k < 11; k++) begin
            wr(8'h4A, pc[k]);
            wr(8'h45, en[k]);
            wr(8'h4D, fq[k]);
            wr(8'h4C, du[k]);
            crit = (k == 10);
            pwm(per[k], hi[k]);
        end
        crit = 1'b0;
        $display("done pwm");
    endtask : t_pwm
    task automatic t_table;
        int tp[6] = '{41, 42, 50, 62, 60, 53};
        logic [7:0] ex[6] = '{0, 4, 4, 8, 8, 4};
        wr(8'h45, 8'h00);
        wr(8'h4D, 8'h08);
        wr(8'h4A, 8'h20);
        wr(8'h50, 8'd20);
        wr(8'h51, 8'd4);
        wr(8'h52, 8'd30);
        wr(8'h53, 8'd8);
        for (int k = 0; k < 6; k++) begin
            remote_temp = 9'(tp[k]);
            repeat (3) @(negedge core_clk);
            rchk(8'h48, ex[k]);
        end
        wr(8'h4F, 8'h04);
        remote_temp = 9'd61;
        repeat (3) @(negedge core_clk);
        rchk(8'h48, 8'h08);
        pwm(1776, 888);
        $display("done table");
    endtask : t_table
    task automatic t_smooth;
        int n;
        logic p;
        int s[4] = '{20, 10, 6, 4};
        for (int i = 0; i < 4; i++) begin
            wr(8'h4F, 8'h20 | 8'(i));
            remote_temp = i[0] ? 9'd62 : 9'd0;
            reg_addr = 8'h4B;
            // index moves on the first edge, ramp state on the second, readback on the third
            repeat (3) @(negedge core_clk);
            check(reg_rdata & 8'h03, i[0] ? 8'h01 : 8'h02);
            n = 3;
            reg_addr = 8'h48;
            // waiting on the readback bounds a lost step instead of hanging
            while (reg_rdata !== (i[0] ? 8'h08 : 8'h00) && n < 1000) begin
                @(negedge core_clk);
                n++;
            end
            check(n >= 7 * s[i] && n <= 8 * s[i] + 5, 1'b1);
            // pin readback lags two edges through the synchroniser
            p = pin;
            repeat (2) @(negedge core_clk);
            rchk(8'h4B, {5'h00, p, 2'b00});
        end
        $display("done smoothing");
    endtask : t_smooth
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        remote_temp = 9'h000;
        crit = 1'b0;
        clr = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (10) @(negedge core_clk);
        check(fan_pin_oe_n, 1'b1);
        reset_n = 1'b1;
        @(negedge core_clk);
        t_regs();
        t_pwm();
        t_table();
        t_smooth();
        summarize();
    end
endmodule : lut_fan_pwm_control_test
`default_nettype wire
